// >>> verilog/vout_offset_comp_regs.sv
// offset trim, commanded-level readback and loop compensation register bank

// ----------------------------------------------------------------
// register bank
// ----------------------------------------------------------------
module vout_offset_comp_regs
   import vout_offset_comp_pkg::*;
#(
   parameter int OFS_STEP = OFS_STEP_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire reg_req_t reg_req,
   output reg_rsp_t reg_rsp,
   input wire logic i2c_cmd_valid,
   input wire logic [7:0] i2c_cmd_level,
   input wire logic link_cmd_valid,
   input wire logic [7:0] link_cmd_level,
   input wire logic boot_valid,
   input wire logic [7:0] boot_level,
   input wire logic [1:0] voltage_step_select,
   input wire logic [1:0] target_src_select,
   input wire logic [1:0] slew_config,
   output logic [7:0] commanded_level,
   output logic [13:0] target_half_mv,
   output logic [7:0] err_path_gain_x10,
   output logic [7:0] istep_path_gain_x10,
   output logic [7:0] fast_load_line_x10
);

   // ----------------------------------------------------------------
   // decode tables
   // ----------------------------------------------------------------
   // gain code to gain times ten
   function automatic logic [7:0] gain_x10(input logic [3:0] code);
      logic [7:0] g;
      g = 8'h00;
      case (code)
         4'h0: g = 8'h03;
         4'h1: g = 8'h05;
         4'h2: g = 8'h0a;
         4'h3: g = 8'h0f;
         4'h4: g = 8'h14;
         4'h5: g = 8'h19;
         4'h6: g = 8'h1e;
         4'h7: g = 8'h23;
         4'h8: g = 8'h28;
         4'h9: g = 8'h32;
         4'ha: g = 8'h3c;
         4'hb: g = 8'h46;
         default: g = 8'h00;
      endcase
      return g;
   endfunction : gain_x10

   // load-line code to value times ten
   function automatic logic [7:0] ll_x10(input logic [3:0] code);
      logic [7:0] l;
      l = 8'h00;
      case (code)
         4'h0: l = 8'h05;
         4'h1: l = 8'h0a;
         4'h2: l = 8'h0f;
         4'h3: l = 8'h14;
         4'h4: l = 8'h19;
         4'h5: l = 8'h1e;
         4'h6: l = 8'h23;
         4'h7: l = 8'h28;
         4'h8: l = 8'h32;
         4'h9: l = 8'h3c;
         4'ha: l = 8'h46;
         4'hb: l = 8'h5a;
         4'hc: l = 8'h64;
         4'hd: l = 8'h78;
         4'he: l = 8'h82;
         default: l = 8'h96;
      endcase
      return l;
   endfunction : ll_x10

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] level_q, level_d;
   logic [7:0] offset_q;
   logic [7:0] comp_q;
   reg_rsp_t rsp_q, rsp_d;
   logic [7:0] gain_q, gain_d;
   logic [7:0] ll_q;
   logic signed [9:0] ramp_ofs_q, ramp_ofs_d;
   logic [7:0] tick_q, tick_d;
   ramp_state_t ramp_q, ramp_d;
   logic [13:0] target_q;

   // ----------------------------------------------------------------
   // register access decode
   // ----------------------------------------------------------------
   wire hit_rb = reg_req.addr == ADDR_READBACK;
   wire hit_ofs = reg_req.addr == ADDR_OFFSET;
   wire hit_comp = reg_req.addr == ADDR_COMP;
   wire wr_ofs = reg_req.valid && reg_req.write && hit_ofs;
   wire wr_comp = reg_req.valid && reg_req.write && hit_comp;
   wire rd_ok = hit_rb || hit_ofs || hit_comp;
   wire wr_ok = hit_ofs || hit_comp; // readback refuses writes
   wire [7:0] rd_mux = hit_rb ? level_q : hit_ofs ? offset_q : hit_comp ? comp_q : 8'h00;

   // answer one cycle after each request
   always_comb begin
      rsp_d.valid = reg_req.valid;
      rsp_d.ack = reg_req.valid && (reg_req.write ? wr_ok : rd_ok);
      rsp_d.rdata = (reg_req.valid && !reg_req.write) ? rd_mux : 8'h00;
   end

   // ----------------------------------------------------------------
   // commanded level readback
   // ----------------------------------------------------------------
   // link command wins over i2c, i2c over boot; offset never enters here
   assign level_d = link_cmd_valid ? link_cmd_level :
                    i2c_cmd_valid ? i2c_cmd_level :
                    boot_valid ? boot_level : level_q;

   // ----------------------------------------------------------------
   // step size and offset scaling
   // ----------------------------------------------------------------
   wire fine_w = voltage_step_select == STEP_SEL_FINE_A ||
                 voltage_step_select == STEP_SEL_FINE_B;
   wire [4:0] per_step_w = fine_w ? HALF_PER_STEP_FINE : HALF_PER_STEP_COARSE;
   wire [1:0] ofs_unit_w = fine_w ? OFS_UNIT_FINE : OFS_UNIT_COARSE;
   wire signed [9:0] ofs_ext_w = {{2{offset_q[7]}}, offset_q};
   wire signed [9:0] ofs_scaled_w = (ofs_unit_w == OFS_UNIT_COARSE) ?
                                    (ofs_ext_w <<< 1) : ofs_ext_w;
   wire apply_w = target_src_select == SRC_LINK || target_src_select == SRC_I2C;
   wire signed [9:0] goal_w = apply_w ? ofs_scaled_w : 10'sh000;

   // ----------------------------------------------------------------
   // offset ramp
   // ----------------------------------------------------------------
   // quarter of the fast rate, halved again per slew_config code
   wire [7:0] period_w = 8'((OFS_STEP << slew_config) - 1);
   wire at_goal_w = ramp_ofs_q == goal_w;
   wire step_now_w = ramp_q == RAMP_RUN && tick_q == 8'h00 && !at_goal_w;

   // one-hot ramp control
   always_comb begin
      ramp_d = ramp_q;
      tick_d = tick_q;
      ramp_ofs_d = ramp_ofs_q;
      case (ramp_q)
         RAMP_IDLE: begin
            if (!at_goal_w) begin
               ramp_d = RAMP_RUN;
               tick_d = period_w;
            end
         end
         RAMP_RUN: begin
            if (at_goal_w) begin
               ramp_d = RAMP_IDLE;
            end else if (tick_q == 8'h00) begin
               tick_d = period_w;
               ramp_ofs_d = (goal_w > ramp_ofs_q) ? ramp_ofs_q + 10'sh001 :
                                                    ramp_ofs_q - 10'sh001;
            end else begin
               tick_d = tick_q - 8'h01;
            end
         end
         default: ramp_d = RAMP_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // effective target
   // ----------------------------------------------------------------
   wire [12:0] base_w = 13'(level_q * per_step_w);
   wire signed [14:0] sum_w = $signed({2'b00, base_w}) + 15'(ramp_ofs_q);
   wire [13:0] eff_w = sum_w[14] ? 14'h0000 : sum_w[13:0];

   // reserved gain codes keep the previous gain
   assign gain_d = (comp_q[GAIN_MSB:GAIN_LSB] >= GAIN_RESERVED_MIN) ? gain_q :
                   gain_x10(comp_q[GAIN_MSB:GAIN_LSB]);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         level_q <= RST_READBACK;
         offset_q <= RST_OFFSET;
         comp_q <= RST_COMP;
         rsp_q <= '0;
      end else begin
         level_q <= level_d;
         rsp_q <= rsp_d;
         if (wr_ofs) offset_q <= reg_req.wdata;
         if (wr_comp) comp_q <= reg_req.wdata;
      end
   end

   // ramp and derived outputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ramp_q <= RAMP_IDLE;
         tick_q <= 8'h00;
         ramp_ofs_q <= 10'sh000;
         target_q <= 14'h0000;
         gain_q <= 8'h03;
         ll_q <= 8'h05;
      end else begin
         ramp_q <= ramp_d;
         tick_q <= tick_d;
         ramp_ofs_q <= ramp_ofs_d;
         target_q <= eff_w;
         gain_q <= gain_d;
         ll_q <= ll_x10(comp_q[LL_MSB:LL_LSB]);
      end
   end

   assign reg_rsp = rsp_q;
   assign commanded_level = level_q;
   assign target_half_mv = target_q;
   assign err_path_gain_x10 = gain_q; // both ac paths share one gain
   assign istep_path_gain_x10 = gain_q;
   assign fast_load_line_x10 = ll_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_RO_NACK: assert property (
      reg_req.valid && reg_req.write && hit_rb && !link_cmd_valid && !i2c_cmd_valid
      && !boot_valid |=> reg_rsp.valid && !reg_rsp.ack && $stable(commanded_level))
      else $error("write to readback not refused");
   AST_READBACK: assert property (
      link_cmd_valid |=> commanded_level == $past(link_cmd_level))
      else $error("readback missed link command");
   AST_LEVEL_I2C: assert property (
      i2c_cmd_valid && !link_cmd_valid |=> commanded_level == $past(i2c_cmd_level))
      else $error("readback missed i2c command");
   AST_LEVEL_BOOT: assert property (
      boot_valid && !link_cmd_valid && !i2c_cmd_valid |=> commanded_level == $past(boot_level))
      else $error("readback missed boot level");
   AST_LEVEL_HOLD: assert property (
      !link_cmd_valid && !i2c_cmd_valid && !boot_valid |=> $stable(commanded_level))
      else $error("readback moved without a command");
   AST_OFS_WRITE: assert property (
      wr_ofs |=> offset_q == $past(reg_req.wdata))
      else $error("offset write lost");
   AST_RAMP_PACE: assert property (
      $changed(ramp_ofs_q) |=> $stable(ramp_ofs_q) [*8])
      else $error("offset ramp too fast");
   AST_RAMP_UNIT: assert property (
      $changed(ramp_ofs_q) |-> ramp_ofs_q == $past(ramp_ofs_q) + 10'sh001
      || ramp_ofs_q == $past(ramp_ofs_q) - 10'sh001)
      else $error("offset ramp step not one unit");
   AST_SRC_GATE: assert property (
      target_src_select == SRC_BOOT [*2] ##1 ramp_q == RAMP_IDLE |-> ramp_ofs_q == 10'sh000)
      else $error("offset applied with boot source");
   AST_FINE: assert property (
      fine_w && apply_w |-> goal_w == {{2{offset_q[7]}}, offset_q})
      else $error("fine offset scaling wrong");
   AST_COARSE: assert property (
      !fine_w && apply_w |-> goal_w == {offset_q[7], offset_q, 1'b0})
      else $error("coarse offset scaling wrong");
   AST_STEP: assert property (
      ramp_ofs_q == 10'sh000 |=> target_half_mv == 14'($past(level_q) *
      ($past(voltage_step_select[0] ^ voltage_step_select[1]) ?
      HALF_PER_STEP_FINE : HALF_PER_STEP_COARSE)))
      else $error("level step size wrong");
   AST_COMP_FIELDS: assert property (
      wr_comp && reg_req.wdata == 8'h2e |=> ##1 err_path_gain_x10 == 8'h0a
      && fast_load_line_x10 == 8'h82)
      else $error("comp fields misplaced");
   AST_GAIN_TOP: assert property (
      comp_q[7:4] == 4'hb |=> err_path_gain_x10 == 8'h46)
      else $error("gain decode wrong");
   AST_PATHS: assert property (
      err_path_gain_x10 == istep_path_gain_x10)
      else $error("ac paths disagree");
   AST_LL_LOW: assert property (
      comp_q[3:0] == 4'h0 |=> fast_load_line_x10 == 8'h05)
      else $error("load line decode wrong");
   AST_TARGET: assert property (
      ramp_q == RAMP_IDLE && at_goal_w && apply_w && !sum_w[14]
      |=> target_half_mv == 14'($past(level_q) *
      ($past(voltage_step_select[0] ^ voltage_step_select[1]) ?
      HALF_PER_STEP_FINE : HALF_PER_STEP_COARSE)) + 14'($past(goal_w)))
      else $error("target sum wrong");

   COV_RAMP_UP: cover property (wr_ofs ##1 ramp_q == RAMP_RUN ##[1:200] ramp_q == RAMP_IDLE);
   COV_NEG_OFS: cover property (apply_w && ramp_ofs_q < 10'sh000 && at_goal_w);
   COV_RO_WRITE: cover property (reg_req.valid && reg_req.write && hit_rb);
   COV_LINK_SRC: cover property (target_src_select == SRC_LINK && ramp_q == RAMP_RUN);
   COV_COARSE_ST: cover property (!fine_w && apply_w && at_goal_w && offset_q != 8'h00);

endmodule : vout_offset_comp_regs

// >>> include/vout_offset_comp_pkg.sv
// package: register map, field layout, timing and carrier types of the offset/comp bank
package vout_offset_comp_pkg;

   // ----------------------------------------------------------------
   // register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_READBACK = 8'ha7;
   localparam logic [7:0] ADDR_OFFSET = 8'ha8;
   localparam logic [7:0] ADDR_COMP = 8'ha9;
   localparam logic [7:0] RST_READBACK = 8'h00;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_COMP = 8'h00;

   // ----------------------------------------------------------------
   // field positions and codes
   // ----------------------------------------------------------------
   localparam int GAIN_MSB = 7;
   localparam int GAIN_LSB = 4;
   localparam int LL_MSB = 3;
   localparam int LL_LSB = 0;
   localparam logic [3:0] GAIN_RESERVED_MIN = 4'hc;
   localparam logic [1:0] STEP_SEL_FINE_A = 2'h1; // 5 mV step
   localparam logic [1:0] STEP_SEL_FINE_B = 2'h2; // 5 mV step
   localparam logic [1:0] SRC_BOOT = 2'h0; // boot source: offset left out of the target
   localparam logic [1:0] SRC_LINK = 2'h1; // target from identifier link
   localparam logic [1:0] SRC_I2C = 2'h2; // target from i2c command
   localparam logic [4:0] HALF_PER_STEP_FINE = 5'h0a; // 5 mV in 0.5 mV units
   localparam logic [4:0] HALF_PER_STEP_COARSE = 5'h14; // 10 mV in 0.5 mV units
   localparam logic [1:0] OFS_UNIT_FINE = 2'h1; // 0.5 mV per offset lsb
   localparam logic [1:0] OFS_UNIT_COARSE = 2'h2; // 1.0 mV per offset lsb

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int FAST_STEP_NS = 50; // one 0.5 mV step at the fastest slew
   localparam int FAST_STEP_CYCLES = (FAST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QUARTER_DIV = 4;
   localparam int OFS_STEP_CYCLES = FAST_STEP_CYCLES * QUARTER_DIV;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic ack;
      logic [7:0] rdata;
   } reg_rsp_t;

   typedef enum logic [1:0] {
      RAMP_IDLE = 2'b01,
      RAMP_RUN = 2'b10
   } ramp_state_t;

endpackage : vout_offset_comp_pkg

// >>> tb/vout_offset_comp_regs_bench.sv
// testbench: byte accesses, level commands, offset ramp and loop-comp decode of the bank
module vout_offset_comp_regs_bench
   import vout_offset_comp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // signals, dut and clock
   // ----------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   reg_req_t reg_req;
   reg_rsp_t reg_rsp;
   logic i2c_cmd_valid, link_cmd_valid, boot_valid;
   logic [7:0] i2c_cmd_level, link_cmd_level, boot_level, commanded_level;
   logic [1:0] voltage_step_select, target_src_select, slew_config;
   logic [13:0] target_half_mv;
   logic [7:0] err_path_gain_x10, istep_path_gain_x10, fast_load_line_x10;
   int fails = 0;
   int checked = 0;
   // decoded figures times ten, indexed by code
   logic [7:0] gain_tab [12] = '{8'h03, 8'h05, 8'h0a, 8'h0f, 8'h14, 8'h19, 8'h1e, 8'h23,
      8'h28, 8'h32, 8'h3c, 8'h46};
   logic [7:0] ll_tab [16] = '{8'h05, 8'h0a, 8'h0f, 8'h14, 8'h19, 8'h1e, 8'h23, 8'h28,
      8'h32, 8'h3c, 8'h46, 8'h5a, 8'h64, 8'h78, 8'h82, 8'h96};

   // ramp period shortened to the smallest meaningful value
   vout_offset_comp_regs #(.OFS_STEP(9)) i_dut (.core_clk(core_clk), .rst(rst),
      .reg_req(reg_req), .reg_rsp(reg_rsp), .i2c_cmd_valid(i2c_cmd_valid),
      .i2c_cmd_level(i2c_cmd_level), .link_cmd_valid(link_cmd_valid),
      .link_cmd_level(link_cmd_level), .boot_valid(boot_valid), .boot_level(boot_level),
      .voltage_step_select(voltage_step_select), .target_src_select(target_src_select),
      .slew_config(slew_config), .commanded_level(commanded_level),
      .target_half_mv(target_half_mv), .err_path_gain_x10(err_path_gain_x10),
      .istep_path_gain_x10(istep_path_gain_x10), .fast_load_line_x10(fast_load_line_x10));

   // free-running 50 mhz clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      if (fails == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // one byte access: request for one cycle, answer checked the cycle after
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic ea, input logic [7:0] ed);
      @(posedge core_clk);
      #1 reg_req = '{1'b1, w, a, d};
      @(posedge core_clk);
      #1 reg_req.valid = 1'b0;
      check({reg_rsp.valid, reg_rsp.ack}, {1'b1, ea});
      check(reg_rsp.rdata, ed);
   endtask : acc

   // pulse the chosen sources; link gets lvl, i2c lvl+1, boot lvl+2
   task automatic cmd(input logic [2:0] which, input logic [7:0] lvl, input logic [7:0] exp);
      @(posedge core_clk);
      #1 {link_cmd_valid, i2c_cmd_valid, boot_valid} = which;
      link_cmd_level = lvl;
      i2c_cmd_level = lvl + 8'h01;
      boot_level = lvl + 8'h02;
      @(posedge core_clk);
      #1 {link_cmd_valid, i2c_cmd_valid, boot_valid} = 3'h0;
      check(commanded_level, exp);
   endtask : cmd

   // bounded wait for the ramped target to settle on a value
   task automatic wait_target(input logic [13:0] exp);
      for (int n = 0; n < 4000 && target_half_mv !== exp; n++) begin
         @(posedge core_clk);
         #1;
      end
      check(target_half_mv, exp);
      if (target_half_mv !== exp) begin
         wrap_up();
      end
   endtask : wait_target

   task automatic edges(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : edges

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   // hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      fails++;
      wrap_up();
   end

   // main sequence
   initial begin
      reg_req = '0;
      {i2c_cmd_valid, link_cmd_valid, boot_valid} = 3'h0;
      {i2c_cmd_level, link_cmd_level, boot_level} = '0;
      voltage_step_select = 2'h1;
      target_src_select = SRC_BOOT;
      slew_config = 2'h0;
      edges(5);
      rst = 1'b0;
      check(commanded_level, 8'h00);
      check(err_path_gain_x10, 8'h03);
      check(istep_path_gain_x10, 8'h03);
      check(fast_load_line_x10, 8'h05);
      acc(1'b0, ADDR_READBACK, 8'h00, 1'b1, RST_READBACK);
      acc(1'b0, ADDR_OFFSET, 8'h00, 1'b1, RST_OFFSET);
      acc(1'b0, ADDR_COMP, 8'h00, 1'b1, RST_COMP);
      acc(1'b1, ADDR_READBACK, 8'h55, 1'b0, 8'h00);
      acc(1'b0, 8'hb0, 8'h00, 1'b0, 8'h00);
      acc(1'b0, ADDR_READBACK, 8'h00, 1'b1, 8'h00);
      // level sources and their priority
      cmd(3'b001, 8'h20, 8'h22);
      cmd(3'b010, 8'h30, 8'h31);
      cmd(3'b100, 8'h40, 8'h40);
      cmd(3'b111, 8'h50, 8'h50);
      cmd(3'b011, 8'h60, 8'h61);
      acc(1'b0, ADDR_READBACK, 8'h00, 1'b1, 8'h61);
      wait_target(14'h3ca);
      voltage_step_select = 2'h3;
      wait_target(14'h794);
      // offset applied in coarse and fine steps, both range ends
      target_src_select = SRC_I2C;
      acc(1'b1, ADDR_OFFSET, 8'hfc, 1'b1, 8'h00);
      acc(1'b0, ADDR_OFFSET, 8'h00, 1'b1, 8'hfc);
      wait_target(14'h78c);
      check(commanded_level, 8'h61);
      voltage_step_select = 2'h2;
      wait_target(14'h3c6);
      voltage_step_select = 2'h0;
      wait_target(14'h78c);
      acc(1'b1, ADDR_OFFSET, 8'h7f, 1'b1, 8'h00);
      wait_target(14'h892);
      voltage_step_select = 2'h1;
      wait_target(14'h449);
      acc(1'b1, ADDR_OFFSET, 8'h80, 1'b1, 8'h00);
      wait_target(14'h34a);
      // sources that leave the offset out
      target_src_select = 2'h3;
      wait_target(14'h3ca);
      target_src_select = SRC_BOOT;
      edges(20);
      check(target_half_mv, 14'h3ca);
      cmd(3'b100, 8'h00, 8'h00);
      target_src_select = SRC_LINK;
      wait_target(14'h000);
      // ramp pace at two slew settings
      acc(1'b1, ADDR_OFFSET, 8'h00, 1'b1, 8'h00);
      cmd(3'b100, 8'h10, 8'h10);
      wait_target(14'h0a0);
      acc(1'b1, ADDR_OFFSET, 8'h10, 1'b1, 8'h00);
      edges(14);
      check(target_half_mv, 14'h0a1);
      wait_target(14'h0b0);
      slew_config = 2'h1;
      acc(1'b1, ADDR_OFFSET, 8'h00, 1'b1, 8'h00);
      edges(14);
      check(target_half_mv, 14'h0b0);
      edges(13);
      check(target_half_mv, 14'h0af);
      // gain codes 0 to 11 and every load-line code
      for (int i = 0; i < 16; i++) begin
         acc(1'b1, ADDR_COMP, {4'(i % 12), 4'(i)}, 1'b1, 8'h00);
         acc(1'b0, ADDR_COMP, 8'h00, 1'b1, {4'(i % 12), 4'(i)});
         check(err_path_gain_x10, gain_tab[i % 12]);
         check(istep_path_gain_x10, gain_tab[i % 12]);
         check(fast_load_line_x10, ll_tab[i]);
      end
      wrap_up();
   end

endmodule : vout_offset_comp_regs_bench
